// ===== src/ncp_consts.svh
/*
  Constants for the numerics coprocessor port: port addresses, pacing,
  trap vector and idle bus value.
  Assumes inclusion by bare name from the design files.
*/
`ifndef NCP_CONSTS_SVH
`define NCP_CONSTS_SVH

// ----------------------------------------------------------------------
// coprocessor i/o ports, one 16-bit word each
// ----------------------------------------------------------------------
`define NCP_PORT_OPCODE 16'h00f8
`define NCP_PORT_DATA 16'h00fa
`define NCP_PORT_POINTER 16'h00fc
`define NCP_PORT_RESULT 16'h00fe
`define NCP_PORT_FIRST 16'h00f8
`define NCP_PORT_LAST 16'h00fe

// ----------------------------------------------------------------------
// timing and vectors
// ----------------------------------------------------------------------
`define NCP_MIN_XFER_CLKS 5'h11
`define NCP_ERR_VECTOR 8'h10

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
// bus idle: all strobes and selects high, data not driven
`define NCP_BUS_IDLE 39'h00_0000_003b
`define NCP_WAIT_ZERO 4'h0

`endif

// ===== src/ncp_pacer.sv
/*
  Spacing timer for operand transfers: after a start, ready stays low
  until MIN_CLKS clocks have passed.
  Assumes start is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/10ps
`include "ncp_consts.svh"

module ncp_pacer #(
  parameter logic [4:0] MIN_CLKS = `NCP_MIN_XFER_CLKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control
  input wire logic start,
  output logic ready
);

  logic [4:0] count;

  // load on start, then run down to zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 5'h00;
    end else if (start) begin
      count <= MIN_CLKS - 5'h01;
    end else if (count != 5'h00) begin
      count <= count - 5'h01;
    end
  end

  assign ready = (count == 5'h00);

endmodule : ncp_pacer

// ===== src/ncp_pkg.sv
/*
  Types shared by the numerics coprocessor port modules.
  Assumes ncp_consts.svh supplies the numeric constants.
*/
package ncp_pkg;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_ERRCHK = 4'h1,
    S_STAT   = 4'h2,
    S_PTR    = 4'h3,
    S_OPER   = 4'h4,
    S_BUS    = 4'h5,
    S_DONE   = 4'h6
  } ncp_state_t;

  // ----------------------------------------------------------------------
  // one numerics instruction from the execution unit
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] opcode;
    logic [15:0] pointer;
    logic [3:0] words;
    logic store;
    logic ptr_write;
    logic locked;
  } ncp_req_t;

  // ----------------------------------------------------------------------
  // local bus outputs of one i/o cycle
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic data_oe;
    logic rd_n;
    logic wr_n;
    logic den_n;
    logic dt_r;
    logic gcs_n;
    logic sel_n;
  } ncp_bus_t;

endpackage : ncp_pkg

// ===== src/ncp_port.sv
/*
  Processor-side numerics coprocessor port: sequences opcode write,
  opcode status read, pointer write and paced operand transfers as
  ordinary i/o cycles on the local bus, with hold and peripheral sharing,
  bus lock and error trapping.
  Assumes synchronous inputs, an external coprocessor on the local bus
  and an execution unit that presents one instruction at a time.
*/
// Functional notes
// - all coprocessor traffic uses dedicated 16-bit i/o ports
// - opcode is written to port f8 before any operand transfer
// - coprocessor returns an opcode status word, read from port fe
// - processor does all memory moves; each transfer spaced at least 17 clocks
// - f8 opcode/status, fa data, fc pointers write-only, fe status read-only
// - trap bit clear and no coprocessor gives undefined results
// - coprocessor cycles drive control pins like any i/o cycle
// - each coprocessor cycle ends only on bus ready; the port also ends it on chip-select ready if cs_ext_ready_ignored
// - general chip-select covering the ports goes active on them
// - numerics select asserts only on coprocessor port accesses
// - refresh and dma may use the bus between coprocessor cycles
// - hold masters may take the bus between cycles, without time limit
// - a locked numerics instruction keeps bus lock for its whole length
// - error input sampled at start of each numerics instruction
// - active error gives interrupt type 16 instead of the instruction
// - select, busy, operand request, error share pins with chip-selects
// - coprocessor seen at reset end selects enhanced mode pin functions
`timescale 1ns/10ps
`include "ncp_consts.svh"

module ncp_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction request from the execution unit
  input wire logic req_valid,
  input wire ncp_pkg::ncp_req_t req,
  output logic req_ready,
  output logic done,
  // operand words
  input wire logic [15:0] op_wdata,
  input wire logic op_wvalid,
  output logic op_wtaken,
  output logic [15:0] op_rdata,
  output logic op_rvalid,
  output logic [15:0] opcode_status,
  output logic status_valid,
  // traps
  input wire logic numerics_trap_bit,
  output logic err_trap,
  output logic escape_trap,
  output logic [7:0] trap_vector,
  // chip-select programming
  input wire logic [15:0] cs_base,
  input wire logic [15:0] cs_top,
  input wire logic [3:0] cs_waits,
  input wire logic cs_ext_ready_ignored,
  // coprocessor handshake and shared pin
  input wire logic cop_present,
  input wire logic operand_request,
  input wire logic error_n,
  input wire logic midrange_select_three_n,
  output logic numerics_select_n,
  output logic enhanced,
  // local bus
  output ncp_pkg::ncp_bus_t bus,
  input wire logic [15:0] io_rdata,
  input wire logic ext_ready,
  output logic bus_lock_n,
  // bus sharing
  input wire logic hold,
  output logic hlda,
  input wire logic periph_req,
  output logic periph_grant
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  ncp_pkg::ncp_state_t state;
  ncp_pkg::ncp_state_t next_state;
  ncp_pkg::ncp_state_t after;
  ncp_pkg::ncp_state_t launch_after;
  ncp_pkg::ncp_req_t req_q;
  ncp_pkg::ncp_bus_t next_bus;
  logic [3:0] words_left;
  logic [3:0] wait_cnt;
  logic strap_taken;
  logic accept;
  logic can_launch;
  logic oper_ok;
  logic launch_go;
  logic launch_wr;
  logic data_launch;
  logic [15:0] launch_addr;
  logic [15:0] launch_wdata;
  logic cop_hit;
  logic cs_hit;
  logic pace_ready;
  logic ready_now;
  logic bus_done;
  logic trap_now;
  logic err_now;

  // ----------------------------------------------------------------------
  // launch decode
  // ----------------------------------------------------------------------
  // hold is refused under lock; refresh/dma still slip in between cycles
  // bus free between cycles
  assign can_launch = !hlda && !periph_grant && !periph_req && (!bus_lock_n || !hold);
  assign oper_ok = (words_left != 4'h0) && (operand_request || !enhanced) &&
                   pace_ready && (req_q.store || op_wvalid);
  assign trap_now = (state == ncp_pkg::S_ERRCHK) && numerics_trap_bit;
  assign err_now = (state == ncp_pkg::S_ERRCHK) && !numerics_trap_bit && !error_n;
  assign launch_go = can_launch && (
    (state == ncp_pkg::S_ERRCHK && !numerics_trap_bit && error_n) ||
    (state == ncp_pkg::S_STAT) ||
    (state == ncp_pkg::S_PTR && req_q.ptr_write) ||
    (state == ncp_pkg::S_OPER && oper_ok));
  assign data_launch = launch_go && (state == ncp_pkg::S_OPER);

  assign launch_addr = (state == ncp_pkg::S_ERRCHK) ? `NCP_PORT_OPCODE :
                       (state == ncp_pkg::S_STAT) ? `NCP_PORT_RESULT :
                       (state == ncp_pkg::S_PTR) ? `NCP_PORT_POINTER : `NCP_PORT_DATA;
  assign launch_wr = (state != ncp_pkg::S_STAT) &&
                     !(state == ncp_pkg::S_OPER && req_q.store);
  assign launch_wdata = (state == ncp_pkg::S_ERRCHK) ? req_q.opcode :
                        (state == ncp_pkg::S_PTR) ? req_q.pointer : op_wdata;
  assign launch_after = (state == ncp_pkg::S_ERRCHK) ? ncp_pkg::S_STAT :
                        (state == ncp_pkg::S_STAT) ? ncp_pkg::S_PTR : ncp_pkg::S_OPER;
  assign accept = req_valid && req_ready && !hlda;

  ncp_sel_decode u_decode (
    .addr(launch_addr),
    .cs_base(cs_base),
    .cs_top(cs_top),
    .cop_hit(cop_hit),
    .cs_hit(cs_hit)
  );

  ncp_pacer u_pacer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(data_launch),
    .ready(pace_ready)
  );

  // build the outputs of a normal i/o cycle, strobes asserted at once
  function automatic ncp_pkg::ncp_bus_t make_cycle(input logic [15:0] a,
      input logic [15:0] d, input logic wr, input logic cs, input logic cop);
    ncp_pkg::ncp_bus_t b;
    b = ncp_pkg::ncp_bus_t'(`NCP_BUS_IDLE);
    b.addr = a;
    b.wdata = wr ? d : 16'h0000;
    b.data_oe = wr;
    b.rd_n = wr;
    b.wr_n = !wr;
    b.den_n = 1'b0;
    b.dt_r = wr;
    b.gcs_n = !cs;
    b.sel_n = !cop;
    make_cycle = b;
  endfunction : make_cycle

  assign ready_now = ext_ready ||
                     (!bus.gcs_n && cs_ext_ready_ignored && (wait_cnt >= cs_waits));
  assign bus_done = (state == ncp_pkg::S_BUS) && ready_now;
  assign next_bus = launch_go ? make_cycle(launch_addr, launch_wdata, launch_wr,
                                           cs_hit, cop_hit) :
                    bus_done ? ncp_pkg::ncp_bus_t'(`NCP_BUS_IDLE) : bus;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ncp_pkg::S_IDLE: begin
        if (accept) next_state = ncp_pkg::S_ERRCHK;
      end
      ncp_pkg::S_ERRCHK: begin
        if (trap_now || err_now) next_state = ncp_pkg::S_IDLE;
        else if (launch_go) next_state = ncp_pkg::S_BUS;
      end
      ncp_pkg::S_STAT: begin
        if (launch_go) next_state = ncp_pkg::S_BUS;
      end
      ncp_pkg::S_PTR: begin
        if (!req_q.ptr_write) next_state = ncp_pkg::S_OPER;
        else if (launch_go) next_state = ncp_pkg::S_BUS;
      end
      ncp_pkg::S_OPER: begin
        if (words_left == 4'h0) next_state = ncp_pkg::S_DONE;
        else if (launch_go) next_state = ncp_pkg::S_BUS;
      end
      ncp_pkg::S_BUS: begin
        if (bus_done) next_state = after;
      end
      ncp_pkg::S_DONE: begin
        next_state = ncp_pkg::S_IDLE;
      end
      default: next_state = ncp_pkg::S_IDLE;
    endcase
  end

  // state, request copy and word count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ncp_pkg::S_IDLE;
      after <= ncp_pkg::S_IDLE;
      req_q <= '0;
      words_left <= 4'h0;
    end else begin
      state <= next_state;
      if (launch_go) after <= launch_after;
      if (accept) req_q <= req;
      if (accept) words_left <= req.words;
      else if (data_launch) words_left <= words_left - 4'h1;
    end
  end

  // bus outputs and wait-state count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus <= ncp_pkg::ncp_bus_t'(`NCP_BUS_IDLE);
      wait_cnt <= `NCP_WAIT_ZERO;
    end else begin
      bus <= next_bus;
      wait_cnt <= launch_go ? `NCP_WAIT_ZERO : wait_cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      numerics_select_n <= 1'b1;
    end else begin
      numerics_select_n <= enhanced ? next_bus.sel_n : midrange_select_three_n;
    end
  end

  // strap caught on the first edge after reset release, never by reset itself
  // enhanced mode at reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_taken <= 1'b0;
      enhanced <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      enhanced <= cop_present;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_lock_n <= 1'b1;
    end else if (accept) begin
      bus_lock_n <= !req.locked;
    end else if (next_state == ncp_pkg::S_IDLE) begin
      bus_lock_n <= 1'b1;
    end
  end

  // grants only between cycles; hold never while locked
  // hold handshake
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hlda <= 1'b0;
      periph_grant <= 1'b0;
    end else begin
      hlda <= hold && (hlda || (bus_lock_n && !accept && state != ncp_pkg::S_BUS));
      periph_grant <= periph_req && (periph_grant || (state != ncp_pkg::S_BUS && !launch_go));
    end
  end

  // handshakes and results toward the execution unit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_ready <= 1'b0;
      done <= 1'b0;
      op_wtaken <= 1'b0;
      op_rdata <= 16'h0000;
      op_rvalid <= 1'b0;
      opcode_status <= 16'h0000;
      status_valid <= 1'b0;
    end else begin
      req_ready <= (next_state == ncp_pkg::S_IDLE);
      done <= (state == ncp_pkg::S_DONE);
      op_wtaken <= data_launch && !req_q.store;
      status_valid <= bus_done && (after == ncp_pkg::S_PTR);
      if (bus_done && after == ncp_pkg::S_PTR) opcode_status <= io_rdata;
      op_rvalid <= bus_done && (bus.addr == `NCP_PORT_DATA) && bus.wr_n;
      if (bus_done && bus.addr == `NCP_PORT_DATA && bus.wr_n) op_rdata <= io_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      err_trap <= 1'b0;
      escape_trap <= 1'b0;
      trap_vector <= 8'h00;
    end else begin
      err_trap <= err_now;
      escape_trap <= trap_now;
      if (err_now) trap_vector <= `NCP_ERR_VECTOR;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic opc_seen;
  logic stat_seen;
  logic [4:0] gap;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      opc_seen <= 1'b0;
      stat_seen <= 1'b0;
      gap <= 5'h1f;
    end else begin
      opc_seen <= !accept && (opc_seen || (launch_go && state == ncp_pkg::S_ERRCHK));
      stat_seen <= !accept && (stat_seen || status_valid);
      gap <= data_launch ? 5'h01 : ((gap == 5'h1f) ? gap : gap + 5'h01);
    end
  end

  a_sel_only_ports: assert property (!bus.sel_n |-> bus.addr[15:3] == 13'h001f)
    else $error("numerics select on a foreign address");
  a_cs_in_range: assert property ($fell(bus.den_n) |->
      (!bus.gcs_n == (bus.addr >= cs_base && bus.addr <= cs_top)))
    else $error("chip-select disagrees with range");
  a_opcode_first: assert property ($fell(bus.den_n) && bus.addr == `NCP_PORT_RESULT
      |-> opc_seen)
    else $error("status read before opcode write");
  a_status_before_data: assert property ($fell(bus.den_n) && bus.addr == `NCP_PORT_DATA
      |-> stat_seen)
    else $error("operand moved before status read");
  a_xfer_spacing: assert property (data_launch |-> gap >= 5'h11)
    else $error("operand transfers closer than 17 clocks");
  a_lock_held: assert property (!bus.den_n && req_q.locked |-> !bus_lock_n)
    else $error("locked instruction lost bus lock");
  a_err_trap_16: assert property (err_now |=> err_trap && trap_vector == 8'h10
      && state == ncp_pkg::S_IDLE && bus.den_n)
    else $error("error not trapped as type 16");
  a_hold_quiet: assert property (hlda |-> bus.den_n && bus_lock_n)
    else $error("bus driven during hold");
  a_ctrl_normal: assert property (!bus.den_n |-> bus.dt_r == !bus.wr_n
      && bus.rd_n != bus.wr_n && bus.data_oe == bus.dt_r)
    else $error("i/o control pins inconsistent");
  a_wait_ready: assert property (state == ncp_pkg::S_BUS && !ready_now
      |=> state == ncp_pkg::S_BUS && !bus.den_n)
    else $error("cycle ended without ready");

  c_error_trap: cover property (err_trap);
  c_locked_done: cover property (!bus_lock_n ##1 done);
  c_store_word: cover property (op_rvalid);
  c_hold_mid_instr: cover property (hlda && state == ncp_pkg::S_OPER);

endmodule : ncp_port

// ===== src/ncp_sel_decode.sv
/*
  Address decode for a coprocessor bus cycle: numerics port hit and
  general chip-select range hit.
  Assumes a stable address from the sequencer; pure combinational.
*/
`timescale 1ns/10ps
`include "ncp_consts.svh"

module ncp_sel_decode (
  // cycle address
  input wire logic [15:0] addr,
  // programmed chip-select range, inclusive
  input wire logic [15:0] cs_base,
  input wire logic [15:0] cs_top,
  // decode results
  output logic cop_hit,
  output logic cs_hit
);

  // inclusive range test, shared by both decodes
  function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction : in_span

  // the numerics select only ever answers the even coprocessor ports
  assign cop_hit = in_span(addr, `NCP_PORT_FIRST, `NCP_PORT_LAST) && !addr[0];
  assign cs_hit = in_span(addr, cs_base, cs_top);

endmodule : ncp_sel_decode

// ===== testbench/ncp_cop_model.sv
/*
  Coprocessor model for the port bench: answers i/o cycles, logs writes
  and counts order, spacing, control and select faults.
  Assumes the registered local bus of ncp_port.
*/
`timescale 1ns/10ps

module ncp_cop_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // local bus side
  input wire ncp_pkg::ncp_bus_t bus,
  input wire logic sel_n,
  input wire logic [3:0] lat,
  input wire logic rdy_en,
  output logic [15:0] io_rdata,
  output logic ext_ready,
  output logic operand_request,
  // observations
  output logic [15:0] last_op,
  output logic [15:0] last_ptr,
  output logic [3:0][15:0] wq,
  output logic [7:0] ncyc,
  output logic [7:0] gcs_cyc,
  output logic [3:0][7:0] errs
);
  logic act, rd, busy_q, seen, hit, fin;
  logic [1:0] phase, wn;
  logic [3:0] wcnt, rn;
  logic [7:0] sp;
  logic [15:0] rdata_q, val;

  // ----------------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------------
  // answer only when selected
  assign act = (!bus.rd_n || !bus.wr_n) && !sel_n;
  assign rd = act && !bus.rd_n;
  assign hit = bus.addr[15:3] == 13'h001f && !bus.addr[0];
  assign ext_ready = act && rdy_en && (wcnt >= lat);
  // pin ready off: the chip-select ready ends the cycle after lat waits instead
  assign fin = act && (ext_ready || (!rdy_en && !bus.gcs_n && wcnt >= lat));
  assign operand_request = (phase == 2'h2);
  always_comb begin
    case (bus.addr)
      16'h00f8: val = 16'h3c3c;
      16'h00fa: val = {12'h5a0, rn};
      16'h00fe: val = last_op ^ 16'h0f0f;
      default: val = 16'hbad0;
    endcase
  end
  // released lines toggle, so a stale word never passes as fresh
  assign io_rdata = rd ? val : rdata_q;

  // ----------------------------------------------------------------------
  // cycle log
  // ----------------------------------------------------------------------
  // cycle tracking, capture at the ready edge, fault counts
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      wcnt <= 4'h0;
      rdata_q <= 16'h0;
      sp <= 8'h0;
      seen <= 1'b0;
      phase <= 2'h0;
      wn <= 2'h0;
      rn <= 4'h0;
      last_op <= 16'h0;
      last_ptr <= 16'h0;
      wq <= '0;
      ncyc <= 8'h0;
      gcs_cyc <= 8'h0;
      errs <= '0;
    end else begin
      busy_q <= act && !fin;
      wcnt <= (act && !fin) ? wcnt + 4'h1 : 4'h0;
      rdata_q <= rd ? io_rdata : ~rdata_q;
      if (sp != 8'hff) sp <= sp + 8'h1;
      if (act && !busy_q) begin
        ncyc <= ncyc + 8'h1;
        if (bus.addr == 16'h00fa) begin
          if (phase != 2'h2) errs[0] <= errs[0] + 8'h1;
          if (seen && sp < 8'h10) errs[1] <= errs[1] + 8'h1;
          sp <= 8'h0;
          seen <= 1'b1;
        end
      end
      if (fin) begin
        case (bus.addr)
          16'h00f8: if (!bus.wr_n) begin
            last_op <= bus.wdata;
            phase <= 2'h1;
            seen <= 1'b0;
            wn <= 2'h0;
            rn <= 4'h0;
          end
          16'h00fa: if (bus.wr_n) rn <= rn + 4'h1;
            else begin
            wq[wn] <= bus.wdata;
            wn <= wn + 2'h1;
          end
          16'h00fc: if (!bus.wr_n) last_ptr <= bus.wdata;
          16'h00fe: if (!bus.rd_n) phase <= 2'h2;
          default: ;
        endcase
      end
      // control pins as any i/o cycle
      if (act && (bus.den_n || bus.dt_r !== !bus.wr_n)) errs[2] <= errs[2] + 8'h1;
      if (!sel_n && !(bus.rd_n && bus.wr_n) && !hit) errs[3] <= errs[3] + 8'h1;
      if (act && !bus.gcs_n) gcs_cyc <= gcs_cyc + 8'h1;
    end
  end
endmodule : ncp_cop_model

// ===== testbench/ncp_port_tb.sv
/*
  Self-checking bench for ncp_port: load, store, lock, hold, traps.
  Assumes ncp_cop_model answers the local bus.
*/
`timescale 1ns/10ps

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h got %h", nm, e, g); end end

module ncp_port_tb;
  logic sys_clk, nrst, req_valid, req_ready, done, op_wvalid, op_wtaken, op_rvalid;
  logic status_valid, numerics_trap_bit, err_trap, escape_trap, cs_ext_ready_ignored;
  logic cop_present, operand_request, error_n, midrange_select_three_n;
  logic numerics_select_n, enhanced, ext_ready, bus_lock_n, hold, hlda;
  logic periph_req, periph_grant, rdy_en, hl_seen, pg_seen;
  logic [15:0] op_wdata, op_rdata, opcode_status, cs_base, cs_top, io_rdata;
  logic [15:0] stw, last_op, last_ptr;
  logic [15:0] rdw [0:7];
  logic [7:0] trap_vector, ncyc, gcs_cyc, n0;
  logic [3:0] cs_waits, lat;
  logic [2:0] res;
  logic [3:0][15:0] wq;
  logic [3:0][7:0] errs;
  ncp_pkg::ncp_req_t req;
  ncp_pkg::ncp_bus_t bus;
  int fails, checks, wi, rn, ph, lk_bad, idle_bad, hold_at, per_at, err_at;

  ncp_port uut (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .op_wdata(op_wdata), .op_wvalid(op_wvalid),
    .op_wtaken(op_wtaken), .op_rdata(op_rdata), .op_rvalid(op_rvalid),
    .opcode_status(opcode_status), .status_valid(status_valid),
    .numerics_trap_bit(numerics_trap_bit), .err_trap(err_trap),
    .escape_trap(escape_trap), .trap_vector(trap_vector), .cs_base(cs_base),
    .cs_top(cs_top), .cs_waits(cs_waits), .cs_ext_ready_ignored(cs_ext_ready_ignored),
    .cop_present(cop_present), .operand_request(operand_request), .error_n(error_n),
    .midrange_select_three_n(midrange_select_three_n),
    .numerics_select_n(numerics_select_n), .enhanced(enhanced), .bus(bus),
    .io_rdata(io_rdata), .ext_ready(ext_ready), .bus_lock_n(bus_lock_n), .hold(hold),
    .hlda(hlda), .periph_req(periph_req), .periph_grant(periph_grant));

  ncp_cop_model cop (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .sel_n(numerics_select_n),
    .lat(lat), .rdy_en(rdy_en), .io_rdata(io_rdata), .ext_ready(ext_ready),
    .operand_request(operand_request), .last_op(last_op), .last_ptr(last_ptr), .wq(wq),
    .ncyc(ncyc), .gcs_cyc(gcs_cyc), .errs(errs));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // verdict and end of run
  task end_of_test;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask : end_of_test

  // one instruction: offer, feed load words, log answers and bus sharing
  task automatic run(input logic [15:0] opc, input logic [3:0] w, input logic st, lk);
    int n;
    logic take;
    begin
      ph = 0;
      wi = 0;
      rn = 0;
      lk_bad = 0;
      idle_bad = 0;
      hl_seen = 1'b0;
      pg_seen = 1'b0;
      req = '{opc, 16'h1234, w, st, !st, lk};
      req_valid = 1'b1;
      // ready and hlda hold until the next edge, so this is what the design sees
      take = req_ready && !hlda;
      op_wvalid = 1'b1;
      op_wdata = 16'hc100;
      for (n = 0; n < 3000; n++) begin
        @(negedge sys_clk);
        if (op_rvalid && rn < 8) rdw[rn++] = op_rdata;
        if (status_valid) stw = opcode_status;
        res = {escape_trap, err_trap, done};
        if (res != 3'b000) break;
        if (take) req_valid = 1'b0;
        if (!req_valid) ph++;
        take = req_valid && req_ready && !hlda;
        if (op_wtaken) wi++;
        op_wdata = 16'hc100 + 16'(wi);
        if (ph >= 2 && bus_lock_n !== !lk) lk_bad++;
        if (hlda) hl_seen = 1'b1;
        if (periph_grant) pg_seen = 1'b1;
        if ((hlda || periph_grant) && !(bus.rd_n && bus.wr_n)) idle_bad++;
        hold = hold_at != 0 && ph >= hold_at && ph < hold_at + 30;
        periph_req = per_at != 0 && ph >= per_at && ph < per_at + 20;
        if (err_at != 0 && ph == err_at) error_n = 1'b0;
      end
      if (n == 3000) begin
        fails++;
        $display("Error run timed out");
        end_of_test();
      end
      op_wvalid = 1'b0;
      hold = 1'b0;
      periph_req = 1'b0;
      $display("test %h done", opc);
    end
  endtask : run

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    {nrst, req_valid, op_wvalid, numerics_trap_bit, hold, periph_req} = '0;
    {req, op_wdata, cs_waits, lat, fails, checks, hold_at, per_at, err_at} = '0;
    {cop_present, error_n, midrange_select_three_n, rdy_en} = 4'hf;
    cs_base = 16'h00f8;
    cs_top = 16'h00ff;
    cs_ext_ready_ignored = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK("req_ready", 1'b0, req_ready)
    `CHK("select", 1'b1, numerics_select_n)
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("enhanced", 1'b1, enhanced)
    run(16'hd9c1, 4'h2, 1'b0, 1'b0);
    `CHK("load result", 3'b001, res)
    `CHK("opcode", 16'hd9c1, last_op)
    `CHK("status", 16'hd6ce, stw)
    `CHK("pointer", 16'h1234, last_ptr)
    `CHK("words", 32'hc101c100, {wq[1], wq[0]})
    `CHK("gcs seen", 1'b1, gcs_cyc != 8'h0)
    {cs_base, cs_top, n0, lat, hold_at, per_at} = {32'h010001ff, gcs_cyc, 4'h3, 64'h5_0000002d};
    run(16'hdd07, 4'h3, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) `CHK("store word", {12'h5a0, 4'(i)}, rdw[i])
    `CHK("gcs off", n0, gcs_cyc)
    `CHK("hlda", 1'b1, hl_seen)
    `CHK("grant", 1'b1, pg_seen)
    `CHK("idle", 0, idle_bad)
    {lat, hold_at, per_at} = {4'h0, 64'h3_00000003};
    run(16'hd9e8, 4'h1, 1'b0, 1'b1);
    `CHK("lock", 0, lk_bad)
    `CHK("hlda locked", 1'b0, hl_seen)
    `CHK("grant locked", 1'b1, pg_seen)
    {hold_at, per_at, err_at} = {64'h0, 32'h4};
    run(16'hd9c0, 4'h1, 1'b0, 1'b0);
    `CHK("late error", 3'b001, res)
    {err_at, n0} = {32'h0, ncyc};
    run(16'hd9c0, 4'h1, 1'b0, 1'b0);
    `CHK("error trap", 3'b010, res)
    `CHK("vector", 8'h10, trap_vector)
    `CHK("no cycles", n0, ncyc)
    {error_n, numerics_trap_bit} = 2'b11;
    run(16'hd9c0, 4'h1, 1'b0, 1'b0);
    `CHK("escape", 3'b100, res)
    {numerics_trap_bit, rdy_en, cs_base, cs_top} = {2'b00, 32'h00f800ff};
    {cs_ext_ready_ignored, cs_waits, lat} = 9'h122;
    run(16'hd9c2, 4'h1, 1'b0, 1'b0);
    `CHK("cs ready", 3'b001, res)
    `CHK("cs word", 16'hc100, wq[0])
    `CHK("cs opcode", 16'hd9c2, last_op)
    `CHK("faults", 32'h0, errs)
    {nrst, cop_present, rdy_en} = 3'b001;
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("plain mode", 1'b0, enhanced)
    midrange_select_three_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("shared pin", 1'b0, numerics_select_n)
    end_of_test();
  end
endmodule : ncp_port_tb
